// ==== fcr_defs.svh ====
// register offsets, bit positions, reset values and timing for the flash control registers
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH

// byte addresses on the register bus
`define FCR_OFS_FIRST 12'h220
`define FCR_OFS_SECOND 12'h224

// first control register bit positions
`define FCR_B_READY 0
`define FCR_B_RME 1
`define FCR_B_OVR 2
`define FCR_B_HALT 3
`define FCR_B_BOOT 5
`define FCR_B_PERR 6

// second control register bit positions
`define FCR_B_MWE 1
`define FCR_B_UNIT 4
`define FCR_B_LOCK 6
`define FCR_B_DWAIT 7

// reset values
`define FCR_RST_FIRST 8'h01
`define FCR_RST_SECOND 8'h00

// flash settling time after leaving halt, and the clock rate
`define FCR_TPS_NS 15000
`define FCR_CLK_MHZ 20
// least time: round up to whole cycles
`define FCR_TPS_CYC ((`FCR_TPS_NS * `FCR_CLK_MHZ + 999) / 1000)

`endif

// ==== fcr_pkg.sv ====
// types shared by the flash control register block
package fcr_pkg;

  // bus slave states, one-hot
  typedef enum logic [1:0] {
    FCR_BUS_IDLE = 2'b01,
    FCR_BUS_ACK = 2'b10
  } fcr_bus_st_t;

  // all state of the register block
  typedef struct packed {
    fcr_bus_st_t bus;
    logic [7:0] rdata;
    logic rme;
    logic ovr;
    logic halt;
    logic perr;
    logic mwe;
    logic unit;
    logic lock;
    logic dwait;
    logic boot5;
    logic arm_rme;
    logic arm_ovr;
    logic arm_unit;
    logic [2:0] strap_sync;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic halt_prev;
  } fcr_state_t;

  // state of the settling timer
  typedef struct packed {
    logic [15:0] cnt;
    logic busy;
  } fcr_wake_state_t;

endpackage : fcr_pkg

// ==== fcr_wake_if.sv ====
// carrier between the register block and its settling timer
interface fcr_wake_if;
  logic start;
  logic busy;

  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface : fcr_wake_if

// ==== fcr_wake.sv ====
// settling timer that keeps the flash busy after leaving halt
`include "fcr_defs.svh"
module fcr_wake #(
  parameter int unsigned WAKE_CYCLES = `FCR_TPS_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  fcr_wake_if.tmr wk
);
  import fcr_pkg::*;

  fcr_wake_state_t s_q;
  fcr_wake_state_t s_d;

  // reload on every start so a repeated wake restarts the full wait
  always_comb begin
    s_d = s_q;
    if (wk.start) begin
      s_d.cnt = 16'(WAKE_CYCLES);
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (s_q.cnt <= 16'h0001) begin
        s_d.busy = 1'b0;
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wk.busy = s_q.busy;

  // helper: cycles spent busy since the last start
  logic [15:0] seen_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seen_q <= 16'h0000;
    end else if (wk.start) begin
      seen_q <= 16'h0000;
    end else if (s_q.busy) begin
      seen_q <= seen_q + 16'h0001;
    end
  end

  wake_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
    wk.start |=> wk.busy)
    else $error("settling wait did not start");

  wake_length_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
    $fell(wk.busy) |-> (seen_q == 16'(WAKE_CYCLES)))
    else $error("settling wait has the wrong length");

endmodule : fcr_wake

// ==== fcr_top.sv ====
// flash rewrite control and status registers on an Avalon-MM slave
// Function
// [R1] ready flag reads 0 while any flash command executes, else 1.
// [R2] ready flag also 0 while halted and during the settling wait after halt.
// [R3] flash commands accepted only while rewrite mode enable is 1.
// [R4] rewrite mode enable sets only by a 0 write then a 1 write.
// [R5] software changes rewrite mode enable only with NMI masked or pin high.
// [R6] external-execution mode: write enable from outside flash, read array first.
// [R7] lock override ignores lock bits; erase in this state unlocks the block.
// [R8] lock override works and changes only in rewrite mode; set needs 0-then-1.
// [R9] software leaves lock override alone during program, erase or suspend.
// [R10] halt resets flash control, minimises current, blocks array access.
// [R11] halt acts only in rewrite mode; otherwise bit sets with no effect. The code still drops ready and runs the settling wait.
// [R12] software waits the settling time after clearing halt, and between set-clear.
// [R13] software sets halt from outside flash when busy sticks after an error.
// [R14] no halt in slow or low-current read; no low-current read while halted.
// [R15] program error flag holds the result, cleared only by clear status.
// [R16] software issues no program or erase commands while program error is 1.
// [R17] mode register write enable is read-write; changed with NMI masked.
// [R18] rewrite unit select picks word (0) or byte (1) programming.
// [R19] unit select sets to 1 only by 0-then-1 while rewrite mode enabled.
// [R20] lock state flag holds the read lock status result, 0 locked.
// [R21] data wait 0 adds one read wait on data flash; 1 follows global wait.
// [R22] first register resets to 01, bit 5 set too in user boot mode.
// [R23] writes to read-only bits and unpaired protected sets change nothing.
`include "fcr_defs.svh"
module fcr_top #(
  parameter int unsigned WAKE_CYCLES = `FCR_TPS_CYC
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic boot_mode_i,
  input wire logic cmd_busy_i,
  input wire logic cmd_req_i,
  output logic cmd_accept_o,
  input wire logic prog_done_i,
  input wire logic prog_err_i,
  input wire logic clear_status_i,
  input wire logic lock_read_done_i,
  input wire logic lock_read_val_i,
  input wire logic global_wait_select_i,
  output logic flash_ready_flag_o,
  output logic lock_protect_override_o,
  output logic flash_halt_o,
  output logic array_access_en_o,
  output logic mode_reg_write_enable_o,
  output logic rewrite_unit_select_o,
  output logic data_read_wait_o
);
  import fcr_pkg::*;

  fcr_state_t s_q;
  fcr_state_t s_d;
  fcr_wake_if wk ();

  logic req;
  logic hit_first;
  logic hit_second;
  logic commit_wr;
  logic [7:0] wd;
  logic ready;

  // build the first register's read value from current state
  function automatic logic [7:0] first_view(input fcr_state_t s, input logic rdy);
    logic [7:0] v;
    v = 8'h00;
    v[`FCR_B_READY] = rdy;
    v[`FCR_B_RME] = s.rme;
    v[`FCR_B_OVR] = s.ovr;
    v[`FCR_B_HALT] = s.halt;
    v[`FCR_B_BOOT] = s.boot5;
    v[`FCR_B_PERR] = s.perr;
    return v;
  endfunction : first_view

  // build the second register's read value; reserved bits read zero
  function automatic logic [7:0] second_view(input fcr_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[`FCR_B_MWE] = s.mwe;
    v[`FCR_B_UNIT] = s.unit;
    v[`FCR_B_LOCK] = s.lock;
    v[`FCR_B_DWAIT] = s.dwait;
    return v;
  endfunction : second_view

  // bus decode; a write only lands through byte lane 0
  assign req = avs_read_i | avs_write_i;
  assign hit_first = (avs_address_i == `FCR_OFS_FIRST);
  assign hit_second = (avs_address_i == `FCR_OFS_SECOND);
  assign commit_wr = (s_q.bus == FCR_BUS_ACK) & avs_write_i & avs_byteenable_i[0];
  assign wd = avs_writedata_i[7:0];

  // busy while a command runs, while halted or while the flash settles
  assign ready = ~(cmd_busy_i | s_q.halt | wk.busy); // R1 R2

  // next-state logic for bus, registers, flags and strap capture
  always_comb begin
    s_d = s_q;
    s_d.halt_prev = s_q.halt;

    // one wait cycle, then answer; read data caught on entry to ack
    case (s_q.bus)
      FCR_BUS_IDLE: begin
        if (req) begin
          s_d.bus = FCR_BUS_ACK;
          if (avs_read_i && hit_first) begin
            s_d.rdata = first_view(s_q, ready);
          end else if (avs_read_i && hit_second) begin
            s_d.rdata = second_view(s_q);
          end else begin
            s_d.rdata = 8'h00;
          end
        end
      end
      FCR_BUS_ACK: begin
        s_d.bus = FCR_BUS_IDLE;
      end
      default: begin
        s_d.bus = FCR_BUS_IDLE;
      end
    endcase

    // first register: protected enable needs a 0 write followed by a 1 write
    if (commit_wr && hit_first) begin
      if (!wd[`FCR_B_RME]) begin
        s_d.rme = 1'b0;
        s_d.arm_rme = 1'b1; // R4
      end else begin
        s_d.rme = s_q.rme | s_q.arm_rme; // R4 R23
        s_d.arm_rme = 1'b0;
      end
      // override only changes while rewrite mode is on
      if (s_q.rme) begin
        if (!wd[`FCR_B_OVR]) begin
          s_d.ovr = 1'b0;
          s_d.arm_ovr = 1'b1; // R8
        end else begin
          s_d.ovr = s_q.ovr | s_q.arm_ovr; // R8 R23
          s_d.arm_ovr = 1'b0;
        end
      end else begin
        s_d.arm_ovr = 1'b0; // R8
      end
      // halt bit is stored whatever the mode; its flash and array effect is gated below, its hold on ready is not
      s_d.halt = wd[`FCR_B_HALT]; // R11
    end

    // second register: write enable and data wait are plain, unit select protected
    if (commit_wr && hit_second) begin
      s_d.mwe = wd[`FCR_B_MWE]; // R17
      s_d.dwait = wd[`FCR_B_DWAIT]; // R21
      if (s_q.rme) begin
        if (!wd[`FCR_B_UNIT]) begin
          s_d.unit = 1'b0; // R18
          s_d.arm_unit = 1'b1; // R19
        end else begin
          s_d.unit = s_q.unit | s_q.arm_unit; // R19 R23
          s_d.arm_unit = 1'b0;
        end
      end else begin
        s_d.arm_unit = 1'b0; // R19
      end
    end

    // program error: set wins over clear; a good program never lowers it
    if (prog_done_i && prog_err_i) begin
      s_d.perr = 1'b1; // R15
    end else if (clear_status_i) begin
      s_d.perr = 1'b0; // R15
    end

    // lock state takes each read lock status result
    if (lock_read_done_i) begin
      s_d.lock = lock_read_val_i; // R20
    end

    // boot strap: three stages, taken once the last two agree
    s_d.strap_sync = {s_q.strap_sync[1:0], boot_mode_i};
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt != 2'h3) begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end else if (s_q.strap_sync[2] == s_q.strap_sync[1]) begin
        s_d.boot5 = s_q.strap_sync[2]; // R22
        s_d.strap_done = 1'b1;
      end
    end
  end

  // reset: first register 01, bus idle, everything else cleared
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0; // R22
      s_q.bus <= FCR_BUS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // settling wait starts with the write that clears halt, so ready shows no gap
  assign wk.start = s_q.halt & ~s_d.halt; // R2

  fcr_wake #(
    .WAKE_CYCLES(WAKE_CYCLES)
  ) u_wake (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wk(wk)
  );

  // bus answers; waitrequest stays high until the ack cycle
  assign avs_waitrequest_o = req & (s_q.bus != FCR_BUS_ACK);
  assign avs_readdata_o = {24'h000000, s_q.rdata};

  // halt only bites in rewrite mode; then the array is cut off
  assign flash_halt_o = s_q.halt & s_q.rme; // R10 R11
  assign array_access_en_o = ~(s_q.halt & s_q.rme); // R10

  // commands pass only in rewrite mode and while the flash runs
  assign cmd_accept_o = cmd_req_i & s_q.rme & ~flash_halt_o; // R3

  // override has no effect outside rewrite mode; the sequencer skips lock checks
  assign lock_protect_override_o = s_q.ovr & s_q.rme; // R7 R8
  assign flash_ready_flag_o = ready; // R1
  assign mode_reg_write_enable_o = s_q.mwe; // R17
  assign rewrite_unit_select_o = s_q.unit; // R18

  // data flash reads: one wait by default, else the global choice; writes unaffected
  assign data_read_wait_o = s_q.dwait ? global_wait_select_i : 1'b1; // R21

  // helper: was the last first-register write a zero in the enable bit
  logic last_rme_zero_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_rme_zero_q <= 1'b0;
    end else if (commit_wr && hit_first) begin
      last_rme_zero_q <= ~wd[`FCR_B_RME];
    end
  end

  ready_busy_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
    cmd_busy_i |-> !flash_ready_flag_o)
    else $error("ready shown while a command runs");

  ready_halt_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
    $fell(s_q.halt) |-> !flash_ready_flag_o [*3])
    else $error("ready shown during the settling wait");

  cmd_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
    cmd_accept_o |-> (s_q.rme && cmd_req_i))
    else $error("command accepted outside rewrite mode");

  rme_pair_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
    $rose(s_q.rme) |-> $past(last_rme_zero_q))
    else $error("rewrite mode set without a zero write first");

  ovr_mode_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
    !$stable(s_q.ovr) |-> $past(s_q.rme))
    else $error("lock override changed outside rewrite mode");

  halt_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
    (s_q.halt && !s_q.rme) |-> (array_access_en_o && !flash_halt_o))
    else $error("halt acted outside rewrite mode");

  perr_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
    (s_q.perr && !clear_status_i) |=> s_q.perr)
    else $error("program error flag lost without a clear");

  perr_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
    (prog_done_i && prog_err_i) |=> s_q.perr)
    else $error("program error not recorded");

  unit_mode_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R19
    $rose(s_q.unit) |-> $past(s_q.rme) && $past(s_q.arm_unit))
    else $error("unit select set without pair in rewrite mode");

  bus_answer_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (req && s_q.bus == FCR_BUS_IDLE) |=> !avs_waitrequest_o)
    else $error("bus answer late");

  // bits follow their own write, pulse or strap and hold still otherwise; also the settling wait, data wait and bus return
  halt_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
    (s_q.halt_prev && !s_q.halt) |-> wk.busy)
    else $error("settling wait missing after halt cleared");

  rme_stay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R23
    !(commit_wr && hit_first) |=> $stable(s_q.rme))
    else $error("rewrite mode moved without a write");

  ovr_stay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R23
    !(commit_wr && hit_first) |=> $stable(s_q.ovr))
    else $error("lock override moved without a write");

  unit_stay_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R23
    !(commit_wr && hit_second) |=> $stable(s_q.unit))
    else $error("unit select moved without a write");

  halt_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
    (commit_wr && hit_first) |=> (s_q.halt == $past(wd[`FCR_B_HALT])))
    else $error("halt bit not stored");

  lock_take_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R20
    lock_read_done_i |=> (s_q.lock == $past(lock_read_val_i)))
    else $error("lock status result not taken");

  lock_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R20
    !lock_read_done_i |=> $stable(s_q.lock))
    else $error("lock state moved without a result");

  perr_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
    (clear_status_i && !(prog_done_i && prog_err_i)) |=> !s_q.perr)
    else $error("program error not cleared");

  ovr_pair_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
    $rose(s_q.ovr) |-> $past(s_q.arm_ovr))
    else $error("lock override set without a zero write first");

  dwait_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R21
    !s_q.dwait |-> data_read_wait_o)
    else $error("data flash read wait missing");

  mwe_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R17
    (commit_wr && hit_second) |=> (s_q.mwe == $past(wd[`FCR_B_MWE])))
    else $error("mode register write enable not stored");

  strap_once_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R22
    s_q.strap_done |=> $stable(s_q.boot5))
    else $error("boot strap bit moved after capture");

  bus_return_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_q.bus == FCR_BUS_ACK) |=> (s_q.bus == FCR_BUS_IDLE))
    else $error("bus stuck in answer state");

endmodule : fcr_top

// ==== fcr_seq_model.sv ====
// flash command sequencer stand-in facing the register block
module fcr_seq_model (
  input wire logic clk_i,
  input wire logic cmd_accept_i,
  output logic cmd_busy_o,
  output logic cmd_req_o,
  output logic prog_done_o,
  output logic prog_err_o,
  output logic clear_status_o,
  output logic lock_read_done_o,
  output logic lock_read_val_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels from time zero
  initial begin
    cmd_busy_o = 1'b0;
    cmd_req_o = 1'b0;
    prog_done_o = 1'b0;
    prog_err_o = 1'b0;
    clear_status_o = 1'b0;
    lock_read_done_o = 1'b0;
    lock_read_val_o = 1'b0;
  end

  // ask to start; run only if the block lets the command in
  task automatic start_cmd(output logic ok);
    @(posedge clk_i);
    cmd_req_o <= 1'b1;
    // answer taken at the next rising edge, where the request is dropped
    @(posedge clk_i);
    ok = cmd_accept_i;
    cmd_req_o <= 1'b0;
    cmd_busy_o <= ok;
  endtask : start_cmd

  task automatic end_cmd();
    @(posedge clk_i);
    cmd_busy_o <= 1'b0;
  endtask : end_cmd

  // result only valid with the pulse, so the line flips afterwards
  task automatic prog(input logic e);
    @(posedge clk_i);
    prog_done_o <= 1'b1;
    prog_err_o <= e;
    @(posedge clk_i);
    prog_done_o <= 1'b0;
    prog_err_o <= ~e;
  endtask : prog

  task automatic clear_stat();
    @(posedge clk_i);
    clear_status_o <= 1'b1;
    @(posedge clk_i);
    clear_status_o <= 1'b0;
  endtask : clear_stat

  task automatic lock_rd(input logic v);
    @(posedge clk_i);
    lock_read_done_o <= 1'b1;
    lock_read_val_o <= v;
    @(posedge clk_i);
    lock_read_done_o <= 1'b0;
    lock_read_val_o <= ~v;
  endtask : lock_rd
endmodule : fcr_seq_model

// ==== tb_flash_rewrite_control_regs.sv ====
// self-checking bench for the flash rewrite control registers
`include "fcr_defs.svh"
module tb_flash_rewrite_control_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WAKE = 8;
  localparam logic [11:0] FST = `FCR_OFS_FIRST;
  localparam logic [11:0] SND = `FCR_OFS_SECOND;
  logic clk_i, nrst_i, rd, wr, boot, gws, wreq, ok;
  logic [11:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be;
  logic busy, req, acc, pd, pe, clr, lrd, lrv, rdy, ovr, halt, aen, mwe, unit, dwt;
  int error_cnt = 0;
  int total_checks = 0;
  int n;

  fcr_top #(.WAKE_CYCLES(WAKE)) dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .boot_mode_i(boot), .cmd_busy_i(busy),
    .cmd_req_i(req), .cmd_accept_o(acc), .prog_done_i(pd), .prog_err_i(pe),
    .clear_status_i(clr), .lock_read_done_i(lrd), .lock_read_val_i(lrv),
    .global_wait_select_i(gws), .flash_ready_flag_o(rdy), .lock_protect_override_o(ovr),
    .flash_halt_o(halt), .array_access_en_o(aen), .mode_reg_write_enable_o(mwe),
    .rewrite_unit_select_o(unit), .data_read_wait_o(dwt));

  fcr_seq_model sq (.clk_i(clk_i), .cmd_accept_i(acc), .cmd_busy_o(busy), .cmd_req_o(req),
    .prog_done_o(pd), .prog_err_o(pe), .clear_status_o(clr), .lock_read_done_o(lrd),
    .lock_read_val_o(lrv));

  // free-running 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_reg

  // level outputs are looked at mid-cycle, once settled
  task automatic chk_bit(ref logic g, input logic e);
    @(negedge clk_i);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_bit

  // one avalon transfer; held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int k;
    @(posedge clk_i);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wreq === 1'b0) break;
    end
    if (k == 20) begin
      error_cnt++;
      give_verdict();
    end else begin
      // data taken and request dropped at the accepting edge only
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask : bus

  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr8

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, 4'hf);
    chk_reg(q, e);
  endtask : rdc

  // reset held ten cycles, then room for the strap to settle
  task automatic do_reset(input logic b);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    boot <= b;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask : do_reset

  initial begin
    {nrst_i, rd, wr, boot, adr, wdat, be} = '0;
    gws = 1'b1;
    do_reset(1'b0);
    rdc(FST, 32'h01);
    rdc(12'h228, 32'h0);
    chk_bit(rdy, 1'b1);
    chk_bit(aen, 1'b1);
    sq.start_cmd(ok);
    chk_reg({31'h0, ok}, 32'h0);
    $display("test reset done");
    // unpaired set first, then override outside rewrite mode; nmi never live here
    wr8(FST, 8'h02);
    rdc(FST, 32'h01);
    wr8(FST, 8'h00);
    wr8(FST, 8'h04);
    rdc(FST, 32'h01);
    wr8(FST, 8'h02);
    rdc(FST, 32'h03);
    // the zero half of the override pair only counts once rewrite mode is on
    wr8(FST, 8'h06);
    rdc(FST, 32'h03);
    wr8(FST, 8'h02);
    wr8(FST, 8'h06);
    rdc(FST, 32'h07);
    chk_bit(ovr, 1'b1);
    bus(1'b1, FST, 8'h00, 4'h0);
    rdc(FST, 32'h07);
    $display("test protect done");
    sq.start_cmd(ok);
    chk_reg({31'h0, ok}, 32'h1);
    chk_bit(rdy, 1'b0);
    sq.end_cmd();
    chk_bit(rdy, 1'b1);
    sq.prog(1'b1);
    rdc(FST, 32'h47);
    // the error is cleared before any further program or erase command
    sq.clear_stat();
    rdc(FST, 32'h07);
    sq.lock_rd(1'b1);
    rdc(SND, 32'h40);
    sq.lock_rd(1'b0);
    rdc(SND, 32'h00);
    $display("test flash side done");
    // unit select unpaired, read-only lock bit, wait select both ways
    wr8(SND, 8'h10);
    rdc(SND, 32'h00);
    gws <= 1'b0;
    wr8(SND, 8'hc2);
    rdc(SND, 32'h82);
    chk_bit(mwe, 1'b1);
    chk_bit(dwt, 1'b0);
    wr8(SND, 8'h10);
    rdc(SND, 32'h10);
    chk_bit(unit, 1'b1);
    chk_bit(dwt, 1'b1);
    $display("test second register done");
    // halt set with no command running and slow or low-current reads never on
    wr8(FST, 8'h0a);
    rdc(FST, 32'h0a);
    chk_bit(halt, 1'b1);
    chk_bit(aen, 1'b0);
    sq.start_cmd(ok);
    chk_reg({31'h0, ok}, 32'h0);
    // a clear right after a set waits the settling time first
    repeat (WAKE) @(posedge clk_i);
    wr8(FST, 8'h02);
    // count the cycles ready stays low before the next operation
    for (n = 0; n < 50; n++) begin
      @(negedge clk_i);
      if (rdy === 1'b1) break;
    end
    chk_reg(n, WAKE);
    wr8(FST, 8'h00);
    wr8(FST, 8'h08);
    rdc(FST, 32'h08);
    chk_bit(halt, 1'b0);
    chk_bit(aen, 1'b1);
    $display("test halt done");
    do_reset(1'b1);
    rdc(FST, 32'h21);
    $display("test boot done");
    give_verdict();
  end
endmodule : tb_flash_rewrite_control_regs
